// >>> common/ftr_pkg.sv
package ftr_pkg;
    // ------------------------------------------------------------
    // Register indices (printed offsets; byte address is 4x index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_UNLOCK_KEY = 8'h82;
    localparam logic [7:0] IDX_CMP_LOW = 8'h8c;
    localparam logic [7:0] IDX_CMP_HIGH = 8'h8d;
    localparam logic [7:0] IDX_CELL_LOW = 8'h8e;
    localparam logic [7:0] IDX_CELL_HIGH = 8'h90;
    localparam logic [7:0] IDX_AIN0_LOW = 8'h92;
    localparam logic [7:0] IDX_AIN0_HIGH = 8'h94;
    localparam logic [7:0] IDX_AIN1_LOW = 8'h96;
    localparam logic [7:0] IDX_AIN1_HIGH = 8'h98;
    localparam logic [7:0] IDX_AIN2_LOW = 8'h9a;
    localparam logic [7:0] IDX_AIN2_HIGH = 8'h9c;
    localparam logic [7:0] IDX_AIN3_LOW = 8'h9e;
    localparam logic [7:0] IDX_FAULT_STATUS = 8'hf0;
    localparam logic [7:0] IDX_FAULT_MASK = 8'hf1;
    localparam logic [7:0] IDX_KEY_STATUS = 8'hf2;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int CODE_LSB = 2;
    localparam int CODE_W = 14;
    localparam int CMP_CODE_LSB = 1;
    localparam int CMP_RANGE_BIT = 0;
    localparam logic [15:0] LIMIT_RST = 16'h0000;
    localparam logic [15:0] HIGH_RST = 16'hfffc;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [15:0] MASK_RST = 16'h0000;
    // Channel numbering for the sample port: 0 cell, 1..4 analog in 0..3
    localparam int NCH = 5;
    localparam logic [2:0] CH_CELL = 3'h0;
    // Fault status layout: bit ch = low fault, bit 8+ch = high fault
    localparam int HIGH_BASE = 8;
    // Arbitrary neutral unlock value; only reported through the key status register
    localparam logic [31:0] KEY_VALUE = 32'h1234_5678;
endpackage : ftr_pkg

// >>> rtl/ftr_cmp.sv
`timescale 1ns/1ps
module ftr_cmp (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Sample and limits
    input wire logic valid,
    input wire logic [13:0] sample,
    input wire logic [13:0] low_code,
    input wire logic [13:0] high_code,
    input wire logic low_used,
    input wire logic high_used,
    // Fault pulses
    output logic low_fault,
    output logic high_fault
);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_fault <= 1'b0;
            high_fault <= 1'b0;
        end else begin
            // Offset binary compares as plain unsigned
            low_fault <= valid && low_used && (sample < low_code);
            high_fault <= valid && high_used && (sample > high_code);
        end
    end
endmodule : ftr_cmp

// >>> rtl/ftr_regs.sv
`timescale 1ns/1ps
// How it works
// - Reading the unlock key register always returns zero.
// - Comparator low limit holds 7-bit code in bits 7..1, 25 mV steps.
// - Comparator low bit 0 picks normal or shifted self-test range.
// - Comparator high limit holds 7-bit code in bits 7..1, 25 mV steps.
// - Comparator high bit 0 picks normal or shifted self-test range.
// - Cell low limit holds upper 14 bits in 15..2, for every cell.
// - Cell high limit holds one threshold in 15..2, for every cell.
// - Each 14-bit threshold is offset binary over 0 V to 5 V.
// - Bits 1..0 of threshold registers are written zero, read zero.
// - Analog inputs 0..3 each own a low limit for their samples.
// - Analog inputs 0..2 each own a high limit for their samples.
module ftr_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converted samples
    input wire logic sample_valid,
    input wire logic [2:0] sample_channel,
    input wire logic [15:0] sample_data,
    // Comparator settings
    output logic [6:0] comparator_low_code,
    output logic comparator_low_range_shift,
    output logic [6:0] comparator_high_code,
    output logic comparator_high_range_shift,
    // Key and faults
    output logic key_written,
    output logic [31:0] program_unlock_key,
    output logic irq
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [7:0] idx;
    logic acc;
    logic wr;
    logic rd;
    logic hit;
    logic ready_q;
    logic [31:0] rdata_d;
    assign idx = paddr[9:2];
    // Act on the first access cycle only: a second pass would clear status twice and lose events
    assign acc = psel && penable;
    assign wr = acc && !ready_q && pwrite;
    assign rd = acc && !ready_q && !pwrite;

    // ------------------------------------------------------------
    // Threshold storage
    // ------------------------------------------------------------
    logic [7:0] cmp_low_q;
    logic [7:0] cmp_high_q;
    logic [13:0] low_q [ftr_pkg::NCH];
    logic [13:0] high_q [ftr_pkg::NCH];
    logic [31:0] key_q;
    logic key_pulse_q;
    logic [15:0] status_q;
    logic [15:0] mask_q;
    logic [ftr_pkg::NCH-1:0] low_hit;
    logic [ftr_pkg::NCH-1:0] high_hit;
    logic [7:0] low_idx [ftr_pkg::NCH];
    logic [7:0] high_idx [ftr_pkg::NCH];
    logic [ftr_pkg::NCH-1:0] high_has;

    assign low_idx[0] = ftr_pkg::IDX_CELL_LOW;
    assign low_idx[1] = ftr_pkg::IDX_AIN0_LOW;
    assign low_idx[2] = ftr_pkg::IDX_AIN1_LOW;
    assign low_idx[3] = ftr_pkg::IDX_AIN2_LOW;
    assign low_idx[4] = ftr_pkg::IDX_AIN3_LOW;
    assign high_idx[0] = ftr_pkg::IDX_CELL_HIGH;
    assign high_idx[1] = ftr_pkg::IDX_AIN0_HIGH;
    assign high_idx[2] = ftr_pkg::IDX_AIN1_HIGH;
    assign high_idx[3] = ftr_pkg::IDX_AIN2_HIGH;
    assign high_idx[4] = 8'h00;
    // Analog input 3 has no high limit in this bank
    assign high_has = 5'h0f;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_low_q <= ftr_pkg::CMP_RST;
            cmp_high_q <= ftr_pkg::CMP_RST;
        end else if (wr && idx == ftr_pkg::IDX_CMP_LOW) begin
            cmp_low_q <= pwdata[7:0];
        end else if (wr && idx == ftr_pkg::IDX_CMP_HIGH) begin
            cmp_high_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            comparator_low_code <= 7'h00;
            comparator_low_range_shift <= 1'b0;
            comparator_high_code <= 7'h00;
            comparator_high_range_shift <= 1'b0;
        end else begin
            comparator_low_code <= cmp_low_q[7:ftr_pkg::CMP_CODE_LSB];
            comparator_low_range_shift <= cmp_low_q[ftr_pkg::CMP_RANGE_BIT];
            comparator_high_code <= cmp_high_q[7:ftr_pkg::CMP_CODE_LSB];
            comparator_high_range_shift <= cmp_high_q[ftr_pkg::CMP_RANGE_BIT];
        end
    end

    // One low limit per channel, a high limit for channels 0..3 only, plus its comparator
    for (genvar c = 0; c < ftr_pkg::NCH; c++) begin : g_ch
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                low_q[c] <= ftr_pkg::LIMIT_RST[15:2];
                high_q[c] <= ftr_pkg::HIGH_RST[15:2];
            end else if (wr && idx == low_idx[c]) begin
                // Reserved bits 1..0 are simply not stored
                low_q[c] <= pwdata[15:ftr_pkg::CODE_LSB];
            end else if (wr && high_has[c] && idx == high_idx[c]) begin
                high_q[c] <= pwdata[15:ftr_pkg::CODE_LSB];
            end
        end
        ftr_cmp u_cmp (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .valid(sample_valid && sample_channel == 3'(c)),
            .sample(sample_data[15:ftr_pkg::CODE_LSB]),
            .low_code(low_q[c]),
            .high_code(high_q[c]),
            .low_used(1'b1),
            .high_used(high_has[c]),
            .low_fault(low_hit[c]),
            .high_fault(high_hit[c])
        );
    end

    // ------------------------------------------------------------
    // Unlock key
    // ------------------------------------------------------------
    // A single 32-bit write carries the whole key, so it cannot be split
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_q <= 32'h0000_0000;
            key_pulse_q <= 1'b0;
        end else begin
            key_pulse_q <= wr && idx == ftr_pkg::IDX_UNLOCK_KEY;
            if (wr && idx == ftr_pkg::IDX_UNLOCK_KEY) begin
                key_q <= pwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Fault status, mask, interrupt
    // ------------------------------------------------------------
    logic [15:0] events;
    assign events = {3'h0, high_hit, 3'h0, low_hit};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= 16'h0000;
        end else if (rd && idx == ftr_pkg::IDX_FAULT_STATUS) begin
            // New events in the clearing cycle survive the clear
            status_q <= events;
        end else begin
            status_q <= status_q | events;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= ftr_pkg::MASK_RST;
        end else if (wr && idx == ftr_pkg::IDX_FAULT_MASK) begin
            mask_q <= pwdata[15:0] & 16'h1f1f;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |((status_q | events) & mask_q);
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        hit = 1'b1;
        if (idx == ftr_pkg::IDX_UNLOCK_KEY) begin
            rdata_d = 32'h0000_0000;
        end else if (idx == ftr_pkg::IDX_CMP_LOW) begin
            rdata_d = {24'h00_0000, cmp_low_q};
        end else if (idx == ftr_pkg::IDX_CMP_HIGH) begin
            rdata_d = {24'h00_0000, cmp_high_q};
        end else if (idx == ftr_pkg::IDX_CELL_LOW) begin
            rdata_d = {16'h0000, low_q[0], 2'b00};
        end else if (idx == ftr_pkg::IDX_CELL_HIGH) begin
            rdata_d = {16'h0000, high_q[0], 2'b00};
        end else if (idx == ftr_pkg::IDX_AIN0_LOW) begin
            rdata_d = {16'h0000, low_q[1], 2'b00};
        end else if (idx == ftr_pkg::IDX_AIN0_HIGH) begin
            rdata_d = {16'h0000, high_q[1], 2'b00};
        end else if (idx == ftr_pkg::IDX_AIN1_LOW) begin
            rdata_d = {16'h0000, low_q[2], 2'b00};
        end else if (idx == ftr_pkg::IDX_AIN1_HIGH) begin
            rdata_d = {16'h0000, high_q[2], 2'b00};
        end else if (idx == ftr_pkg::IDX_AIN2_LOW) begin
            rdata_d = {16'h0000, low_q[3], 2'b00};
        end else if (idx == ftr_pkg::IDX_AIN2_HIGH) begin
            rdata_d = {16'h0000, high_q[3], 2'b00};
        end else if (idx == ftr_pkg::IDX_AIN3_LOW) begin
            rdata_d = {16'h0000, low_q[4], 2'b00};
        end else if (idx == ftr_pkg::IDX_FAULT_STATUS) begin
            rdata_d = {16'h0000, status_q};
        end else if (idx == ftr_pkg::IDX_FAULT_MASK) begin
            rdata_d = {16'h0000, mask_q};
        end else if (idx == ftr_pkg::IDX_KEY_STATUS) begin
            rdata_d = {31'h0000_0000, key_q == ftr_pkg::KEY_VALUE};
        end else begin
            hit = 1'b0;
        end
    end

    // Read data is registered so every output leaves a flop; slave adds one wait state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            ready_q <= acc && !ready_q;
            if (acc && !ready_q) begin
                prdata <= rd ? rdata_d : 32'h0000_0000;
                pslverr <= !hit || (paddr[1:0] != 2'b00);
            end else begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end
    assign pready = ready_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_written <= 1'b0;
            program_unlock_key <= 32'h0000_0000;
        end else begin
            key_written <= key_pulse_q;
            program_unlock_key <= key_q;
        end
    end
endmodule : ftr_regs

// >>> tb/ftr_regs_checker.sv
`timescale 1ns/1ps
module ftr_regs_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Settings, key and interrupt
    input wire logic [6:0] comparator_low_code,
    input wire logic comparator_low_range_shift,
    input wire logic [6:0] comparator_high_code,
    input wire logic comparator_high_range_shift,
    input wire logic key_written,
    input wire logic [31:0] program_unlock_key,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic take, rd_lim, wr_cl, wr_ch, wr_key;
    logic [7:0] idx;
    logic [31:0] wd_q;
    assign idx = paddr[9:2];
    assign take = psel && penable && !pready && paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00;
    assign rd_lim = take && !pwrite && idx >= ftr_pkg::IDX_CELL_LOW && idx <= ftr_pkg::IDX_AIN3_LOW;
    assign wr_cl = take && pwrite && idx == ftr_pkg::IDX_CMP_LOW;
    assign wr_ch = take && pwrite && idx == ftr_pkg::IDX_CMP_HIGH;
    assign wr_key = take && pwrite && idx == ftr_pkg::IDX_UNLOCK_KEY;
    // Write data is released after the access, so keep a copy
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_q <= 32'h0000_0000;
        end else if (take) begin
            wd_q <= pwdata;
        end
    end
    chk_key_reads_zero: assert property (take && !pwrite && idx == ftr_pkg::IDX_UNLOCK_KEY
        |=> pready && prdata == 32'h0000_0000) else $error("key read not zero");
    chk_limit_rsvd_zero: assert property (rd_lim |=> prdata[1:0] == 2'b00) else $error("reserved bits set");
    chk_limit_width: assert property (rd_lim |=> prdata[31:16] == 16'h0000) else $error("limit too wide");
    chk_low_code: assert property (wr_cl |-> ##[1:2] comparator_low_code == wd_q[7:1])
        else $error("low code wrong");
    chk_low_range: assert property (wr_cl |-> ##[1:2] comparator_low_range_shift == wd_q[0])
        else $error("low range wrong");
    chk_high_code: assert property (wr_ch |-> ##[1:2] comparator_high_code == wd_q[7:1])
        else $error("high code wrong");
    chk_high_range: assert property (wr_ch |-> ##[1:2] comparator_high_range_shift == wd_q[0])
        else $error("high range wrong");
    chk_key_whole: assert property (wr_key |-> ##2 key_written && program_unlock_key == wd_q)
        else $error("key not kept whole");
    cover property (irq);
    cover property (wr_key ##2 key_written);
    cover property (wr_cl ##2 comparator_low_range_shift);
endmodule : ftr_regs_checker

bind ftr_regs ftr_regs_checker u_chk (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .comparator_low_code, .comparator_low_range_shift, .comparator_high_code,
    .comparator_high_range_shift, .key_written, .program_unlock_key, .irq);

// >>> tb/ftr_regs_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("ERROR %s exp %h got %h", nm, ex, got); end end
module ftr_regs_tb;
    // Stimulus and observed outputs
    logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sample_valid = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [2:0] sample_channel = 3'h0;
    logic [15:0] sample_data = 16'h0000;
    logic [31:0] prdata, key, rd;
    logic pready, pslverr, lsh, hsh, key_written, irq, err;
    logic [6:0] lcode, hcode;
    logic [7:0] ix;
    logic [2:0] chs [4] = '{3'h1, 3'h0, 3'h3, 3'h4};
    logic [15:0] dat [4] = '{16'h8f00, 16'h8f00, 16'ha000, 16'hffff};
    logic [15:0] exs [4] = '{16'h0002, 16'h0000, 16'h0800, 16'h0000};
    int n_mismatch = 0;
    int checks_done = 0;
    int n_key = 0;
    // Pulses of the key strobe, one per key write
    always @(posedge ref_clk) begin
        if (key_written === 1'b1) begin
            n_key++;
        end
    end
    always #4 ref_clk = ~ref_clk;
    ftr_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .sample_channel(sample_channel), .sample_data(sample_data),
        .comparator_low_code(lcode), .comparator_low_range_shift(lsh), .comparator_high_code(hcode),
        .comparator_high_range_shift(hsh), .key_written(key_written), .program_unlock_key(key), .irq(irq));
    task end_of_test;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    // Setup, access, then wait for pready at a rising edge
    task xfer(input logic w, input logic [7:0] i, input logic [31:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : xfer
    task smp(input logic [2:0] ch, input logic [15:0] d);
        @(posedge ref_clk);
        sample_valid <= 1'b1;
        sample_channel <= ch;
        sample_data <= d;
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : smp
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            xfer(1'b0, ftr_pkg::IDX_CELL_LOW + 8'(2 * i), 32'h0000_0000);
            `CHK("limit reset", {16'h0000, (i % 2) ? ftr_pkg::HIGH_RST : ftr_pkg::LIMIT_RST}, rd)
        end
        // Distinct value per register shows each one owns its storage
        for (int i = 0; i < 9; i++) begin
            ix = ftr_pkg::IDX_CELL_LOW + 8'(2 * i);
            xfer(1'b1, ix, {16'hffff, ix, 8'ha7});
        end
        for (int i = 0; i < 9; i++) begin
            ix = ftr_pkg::IDX_CELL_LOW + 8'(2 * i);
            xfer(1'b0, ix, 32'h0000_0000);
            `CHK("limit", {16'h0000, ix, 8'ha4}, rd)
        end
        for (int v = 0; v < 2; v++) begin
            xfer(1'b1, ftr_pkg::IDX_CMP_LOW, v ? 32'h0000_00ab : 32'h0000_0054);
            xfer(1'b1, ftr_pkg::IDX_CMP_HIGH, v ? 32'h0000_0057 : 32'h0000_00a8);
            xfer(1'b0, ftr_pkg::IDX_CMP_LOW, 32'h0000_0000);
            `CHK("cmp low", v ? 32'h0000_00ab : 32'h0000_0054, rd)
            `CHK("low code", v ? 7'h55 : 7'h2a, lcode)
            `CHK("low shift", 1'(v), lsh)
            `CHK("high code", v ? 7'h2b : 7'h54, hcode)
            `CHK("high shift", 1'(v), hsh)
        end
        xfer(1'b1, ftr_pkg::IDX_UNLOCK_KEY, ftr_pkg::KEY_VALUE);
        xfer(1'b0, ftr_pkg::IDX_UNLOCK_KEY, 32'h0000_0000);
        `CHK("key read", 32'h0000_0000, rd)
        `CHK("key out", ftr_pkg::KEY_VALUE, key)
        xfer(1'b0, ftr_pkg::IDX_KEY_STATUS, 32'h0000_0000);
        `CHK("key match", 1'b1, rd[0])
        xfer(1'b1, ftr_pkg::IDX_UNLOCK_KEY, 32'h1234_0000);
        xfer(1'b0, ftr_pkg::IDX_KEY_STATUS, 32'h0000_0000);
        `CHK("key mismatch", 1'b0, rd[0])
        `CHK("key pulses", 2, n_key)
        xfer(1'b0, 8'h10, 32'h0000_0000);
        `CHK("unmapped", 1'b1, err)
        // Faults judged against the limits left by the storage pass
        xfer(1'b1, ftr_pkg::IDX_FAULT_MASK, 32'h0000_1f1f);
        for (int k = 0; k < 4; k++) begin
            smp(chs[k], dat[k]);
            `CHK("irq", |exs[k], irq)
            xfer(1'b0, ftr_pkg::IDX_FAULT_STATUS, 32'h0000_0000);
            `CHK("status", {16'h0000, exs[k]}, rd)
            repeat (2) @(posedge ref_clk);
            `CHK("irq clear", 1'b0, irq)
        end
        xfer(1'b1, ftr_pkg::IDX_FAULT_MASK, 32'h0000_0000);
        smp(3'h1, 16'h8f00);
        `CHK("irq masked", 1'b0, irq)
        xfer(1'b0, ftr_pkg::IDX_FAULT_STATUS, 32'h0000_0000);
        `CHK("masked status", 32'h0000_0002, rd)
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        end_of_test();
    end
endmodule : ftr_regs_tb
